// File: core/rbc_bit_cell.sv
// One register bit with a selectable access attribute.
// Assumes write, read and event inputs are synchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none
module rbc_bit_cell
    import rbc_pkg::*;
#(
    parameter rbc_attr_t ATTR = RBC_RW,
    parameter logic RESET_VAL = 1'b0,
    parameter logic SOFT_RESET_IMMUNE = 1'b0
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic soft_reset_i,
    input wire logic wr_i,
    input wire logic wdata_i,
    input wire logic rd_i,
    input wire logic hw_i,
    output logic value_o
);

    typedef struct packed {
        logic val;
    } rbc_cell_state_t;

    rbc_cell_state_t state_q;
    rbc_cell_state_t state_d;

    // ****************************************************************
    // Next value by attribute
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        unique case (ATTR)
            RBC_RW, RBC_WO: begin
                if (wr_i) begin
                    state_d.val = wdata_i; // [R1] [R3]
                end
            end
            RBC_RO: begin
                state_d.val = hw_i; // [R2]
            end
            RBC_WRITE_ONE_CLEAR: begin
                if (wr_i && wdata_i) begin
                    state_d.val = 1'b0; // [R4]
                end
                if (hw_i) begin
                    state_d.val = 1'b1; // [R15]
                end
            end
            RBC_WRITE_ANY_CLEAR: begin
                if (wr_i) begin
                    state_d.val = 1'b0; // [R5]
                end
                if (hw_i) begin
                    state_d.val = 1'b1; // [R15]
                end
            end
            RBC_READ_CLEAR, RBC_LATCH_HIGH: begin
                // A read releases the latch, but a present condition holds it high.
                if (rd_i) begin
                    state_d.val = 1'b0; // [R6] [R7] [R8]
                end
                if (hw_i) begin
                    state_d.val = 1'b1; // [R8] [R15]
                end
            end
            RBC_LATCH_LOW: begin
                if (rd_i) begin
                    state_d.val = 1'b1; // [R7]
                end
                if (!hw_i) begin
                    state_d.val = 1'b0; // [R7] [R15]
                end
            end
            RBC_SELF_CLEARING: begin
                if (state_q.val) begin
                    state_d.val = 1'b0; // [R9]
                end
                if (wr_i && wdata_i) begin
                    state_d.val = 1'b1; // [R9]
                end
            end
            RBC_SELF_SETTING: begin
                if (!state_q.val) begin
                    state_d.val = 1'b1; // [R10]
                end
                if (wr_i && !wdata_i) begin
                    state_d.val = 1'b0; // [R10]
                end
            end
            RBC_STICKY: begin
                if (wr_i && !wdata_i && !hw_i) begin
                    state_d.val = 1'b0; // [R11]
                end
                if (hw_i) begin
                    state_d.val = 1'b1; // [R11] [R15]
                end
            end
            default: begin
                state_d.val = 1'b0;
            end
        endcase
        // Software reset overrides every other action in its cycle; immune bits simply hold.
        if (soft_reset_i) begin
            state_d.val = SOFT_RESET_IMMUNE ? state_q.val : RESET_VAL; // [R12]
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= '{val: RESET_VAL}; // [R12]
        end else begin
            state_q <= state_d;
        end
    end

    assign value_o = state_q.val;

endmodule // rbc_bit_cell
`default_nettype wire

// File: core/rbc_pkg.sv
// Package of the register bit attribute cell library.
// Assumes one system clock, an active-low hardware reset and a synchronous software reset pulse.
package rbc_pkg;

    // ****************************************************************
    // Access attribute encodings
    // ****************************************************************
    typedef enum logic [3:0] {
        RBC_RW              = 4'h0,
        RBC_RO              = 4'h1,
        RBC_WO              = 4'h2,
        RBC_WRITE_ONE_CLEAR = 4'h3,
        RBC_WRITE_ANY_CLEAR = 4'h4,
        RBC_READ_CLEAR      = 4'h5,
        RBC_LATCH_LOW       = 4'h6,
        RBC_LATCH_HIGH      = 4'h7,
        RBC_SELF_CLEARING   = 4'h8,
        RBC_SELF_SETTING    = 4'h9,
        RBC_STICKY          = 4'hA,
        RBC_RESERVED        = 4'hB
    } rbc_attr_t;

    // ****************************************************************
    // Geometry and reset values
    // ****************************************************************
    localparam int RBC_WIDTH = 16;
    localparam logic [15:0] RBC_RESET_VALUE = 16'h0000;
    localparam logic [15:0] RBC_RESERVED_READ = 16'h0000;

endpackage

// File: core/rbc_register.sv
// Summary of operation
// [R1] Read/write bits keep the last written value and return it on reads.
// [R2] Read-only bits ignore writes and follow only their hardware source.
// [R3] Write-only bits accept writes; reads return no defined value.
// [R4] Write-one-to-clear bits clear on a written one; zero leaves them.
// [R5] Write-anything-to-clear bits clear on any write and read back their value.
// [R6] Read-to-clear fields clear when read; writes do nothing.
// [R7] Latch-low and latch-high bits capture events until the register is read.
// [R8] Latch-high bits stay high until read, then follow the live condition.
// [R9] Self-clearing bits drop to zero alone after being set; zeros ignored.
// [R10] Self-setting bits return to one alone after being cleared; ones ignored.
// [R11] Sticky bits set on condition, cleared by writing zero once it ends.
// [R12] Soft-reset-immune bits keep value on software reset; only hardware reset clears.
// [R13] Software writes zeros to reserved fields and ignores their read value.
// [R14] Software does not access reserved register addresses.
// [R15] A hardware set in the same cycle as a clear wins.
//
// A 16-bit register whose bits each carry their own access attribute.
// Assumes the access strobes come from a management port on the same clock.
`timescale 1ns/1ns
`default_nettype none
module rbc_register
    import rbc_pkg::*;
#(
    parameter rbc_attr_t ATTR [RBC_WIDTH] = '{default: RBC_RW},
    parameter logic [15:0] RESET_VAL = RBC_RESET_VALUE,
    parameter logic [15:0] SOFT_RESET_IMMUNE = 16'h0000
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic soft_reset_i,
    input wire logic wr_i,
    input wire logic [15:0] wdata_i,
    input wire logic rd_i,
    input wire logic [15:0] hw_i,
    output logic [15:0] rdata_o,
    output logic [15:0] value_o
);

    typedef struct packed {
        logic [15:0] rdata;
    } rbc_reg_state_t;

    rbc_reg_state_t state_q;
    rbc_reg_state_t state_d;
    logic [15:0] cell_val;

    // ****************************************************************
    // Read masking by attribute
    // ****************************************************************
    function automatic logic rbc_readable(input rbc_attr_t a);
        return (a != RBC_WO) && (a != RBC_RESERVED);
    endfunction

    // ****************************************************************
    // Bit cells
    // ****************************************************************
    for (genvar i = 0; i < RBC_WIDTH; i++) begin : g_bit
        rbc_bit_cell #(
            .ATTR(ATTR[i]),
            .RESET_VAL(RESET_VAL[i]),
            .SOFT_RESET_IMMUNE(SOFT_RESET_IMMUNE[i])
        ) u_cell (
            .clk_i(clk_i),
            .reset_n_i(reset_n_i),
            .soft_reset_i(soft_reset_i),
            .wr_i(wr_i),
            .wdata_i(wdata_i[i]),
            .rd_i(rd_i),
            .hw_i(hw_i[i]),
            .value_o(cell_val[i])
        );
    end

    // ****************************************************************
    // Read data register
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        if (rd_i) begin
            for (int j = 0; j < RBC_WIDTH; j++) begin
                // Write-only and reserved bits read as a fixed value. [R3] [R13]
                state_d.rdata[j] = rbc_readable(ATTR[j]) ? cell_val[j] : RBC_RESERVED_READ[j];
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= '{rdata: RBC_RESET_VALUE};
        end else begin
            state_q <= state_d;
        end
    end

    assign rdata_o = state_q.rdata;
    assign value_o = cell_val;

endmodule // rbc_register
`default_nettype wire

// File: dv/rbc_register_monitor.sv
// Port assertions for one rbc_register.
// Assumes the bit layout and reset values that the bench gives the register.
`timescale 1ns/1ns
`default_nettype none
module rbc_monitor (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic soft_reset_i,
    input wire logic wr_i,
    input wire logic [15:0] wdata_i,
    input wire logic rd_i,
    input wire logic [15:0] hw_i,
    input wire logic [15:0] rdata_o,
    input wire logic [15:0] value_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wire logic ns = !soft_reset_i;
    a_rw_load: assert property (wr_i && ns |=> value_o[0] == $past(wdata_i[0])) else $error("rw");
    a_w1c_clear: assert property (wr_i && wdata_i[3] && !hw_i[3] && ns |=> !value_o[3]) else $error("w1c");
    a_set_wins: assert property (hw_i[3] && ns |=> value_o[3]) else $error("set");
    a_rc_clear: assert property (rd_i && !hw_i[5] && ns |=> !value_o[5] && rdata_o[5] == $past(value_o[5]))
        else $error("rc");
    a_lh_hold: assert property (value_o[7] && !rd_i && ns |=> value_o[7]) else $error("lh");
    a_sc_pulse: assert property (value_o[8] && !(wr_i && wdata_i[8]) && ns |=> !value_o[8])
        else $error("sc");
    a_ss_back: assert property (!value_o[9] && !(wr_i && !wdata_i[9]) && ns |=> value_o[9])
        else $error("ss");
    a_sticky_set: assert property (hw_i[10] && ns |=> value_o[10]) else $error("sticky");
    a_soft_keep: assert property (soft_reset_i |=> $stable(value_o[12]) && (value_o & 16'hEFFF) == 16'h0201)
        else $error("soft");
endmodule // rbc_monitor
bind rbc_register rbc_monitor u_mon (.clk_i, .reset_n_i, .soft_reset_i, .wr_i, .wdata_i, .rd_i, .hw_i,
    .rdata_o, .value_o);
`default_nettype wire

// File: dv/rbc_register_tb_top.sv
// Self-checking bench for rbc_register with at least one bit of each attribute.
// Assumes the monitor is bound to the register instance.
`timescale 1ns/1ns
`default_nettype none
module rbc_register_tb_top import rbc_pkg::*; ;
    localparam rbc_attr_t A [RBC_WIDTH] = '{RBC_RW, RBC_RO, RBC_WO, RBC_WRITE_ONE_CLEAR, RBC_WRITE_ANY_CLEAR,
        RBC_READ_CLEAR, RBC_LATCH_LOW, RBC_LATCH_HIGH, RBC_SELF_CLEARING, RBC_SELF_SETTING, RBC_STICKY,
        RBC_RESERVED, RBC_RW, RBC_WRITE_ONE_CLEAR, RBC_RW, RBC_LATCH_HIGH};
    localparam logic [15:0] RV = 16'h0201;
    localparam logic [15:0] IM = 16'h1000;
    localparam logic [15:0] RM = 16'hF7FB;
    localparam logic [15:0] WM = 16'hF7FF;
    logic clk_i = 1'b0;
    logic reset_n_i, sr, wr, rd;
    logic [15:0] wd, hw, rdata, val, ev, er;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    int seed = 72157;
    always #20 clk_i = ~clk_i;
    // The bench reaches only this one register and never a reserved location.
    rbc_register #(.ATTR(A), .RESET_VAL(RV), .SOFT_RESET_IMMUNE(IM)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .soft_reset_i(sr), .wr_i(wr), .wdata_i(wd), .rd_i(rd), .hw_i(hw), .rdata_o(rdata), .value_o(val));
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic chk(logic [15:0] g, logic [15:0] e, logic [15:0] m);
        total_checks++;
        if ((g & m) !== (e & m)) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h mask %h", $time, g, e, m);
        end
    endtask
    // Next bit values from the inputs that the design samples at this edge.
    function automatic logic [15:0] nxt(logic [15:0] v);
        logic [15:0] n;
        for (int i = 0; i < 16; i++) begin
            case (A[i])
                RBC_RW, RBC_WO: n[i] = wr ? wd[i] : v[i];
                RBC_RO: n[i] = hw[i];
                RBC_WRITE_ONE_CLEAR: n[i] = hw[i] | v[i] & !(wr & wd[i]);
                RBC_WRITE_ANY_CLEAR: n[i] = hw[i] | v[i] & !wr;
                RBC_READ_CLEAR, RBC_LATCH_HIGH: n[i] = hw[i] | v[i] & !rd;
                RBC_LATCH_LOW: n[i] = hw[i] & (v[i] | rd);
                RBC_SELF_CLEARING: n[i] = wr & wd[i];
                RBC_SELF_SETTING: n[i] = !(wr & !wd[i]);
                RBC_STICKY: n[i] = hw[i] | v[i] & !(wr & !wd[i]);
                default: n[i] = 1'b0;
            endcase
            if (sr) n[i] = IM[i] ? v[i] : RV[i];
        end
        return n;
    endfunction
    task automatic step(logic w, logic [15:0] d, logic r, logic [15:0] h, logic s);
        @(posedge clk_i);
        if (rd) er = ev & RM;
        ev = nxt(ev);
        wr <= w;
        wd <= d & WM;
        rd <= r;
        hw <= h;
        sr <= s;
        @(negedge clk_i);
        chk(val, ev, 16'h5001);
        chk(val, ev, 16'h0006);
        chk(val, ev, 16'h2038);
        chk(val, ev, 16'h80C0);
        chk(val, ev, 16'h0700);
        chk(rdata, er, RM);
    endtask
    initial begin
        logic [31:0] q;
        logic [31:0] p;
        {sr, wr, rd, wd, hw} = '0;
        reset_n_i = 1'b0;
        ev = RV;
        er = '0;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        step(1'b1, 16'hFFFF, 1'b0, 16'h0040, 1'b0);
        step(1'b0, 16'h0000, 1'b1, 16'h00E8, 1'b0);
        step(1'b1, 16'hFFFF, 1'b1, 16'h0048, 1'b0);
        step(1'b1, 16'h0000, 1'b0, 16'h0040, 1'b1);
        step(1'b1, 16'h0000, 1'b0, 16'h0440, 1'b0);
        step(1'b1, 16'h0000, 1'b1, 16'h0040, 1'b0);
        repeat (2) begin
            repeat (1500) begin
                q = $random(seed);
                p = $random(seed);
                step(q[0], p[15:0], q[1] & ~&q[7:4], q[31:16] & p[31:16] ^ 16'h0040, &q[7:4]);
            end
            @(posedge clk_i);
            reset_n_i <= 1'b0;
            {sr, wr, rd, wd, hw} <= '0;
            ev = RV;
            er = '0;
            @(negedge clk_i);
            chk(val, RV, 16'hFFFF);
            chk(rdata, 16'h0000, 16'hFFFF);
            @(posedge clk_i);
            reset_n_i <= 1'b1;
        end
        finish_test();
    end
endmodule // rbc_register_tb_top
`default_nettype wire
